// file: inc/ast_pkg.sv
// constants and types shared by the serial transmitter block
package ast_pkg;

  // register map, byte addresses on the plain register port
  localparam logic [3:0] AST_ADDR_CTRL = 4'h0;
  localparam logic [3:0] AST_ADDR_STATUS = 4'h4;
  localparam logic [3:0] AST_ADDR_DATA = 4'h8;

  // control register field positions
  localparam int AST_CTRL_TE_BIT = 0;
  localparam int AST_CTRL_NINTH_BIT = 1;
  localparam int AST_CTRL_PE_BIT = 2;
  localparam int AST_CTRL_ODD_BIT = 3;
  localparam int AST_CTRL_BRK_BIT = 4;
  localparam int AST_CTRL_OD_BIT = 5;
  localparam int AST_CTRL_WIDTH = 6;

  // status register field positions
  localparam int AST_STAT_DONE_BIT = 7;
  localparam int AST_STAT_EMPTY_BIT = 8;

  // data register field positions
  localparam int AST_DATA_NINTH_BIT = 8;
  localparam int AST_DATA_WIDTH = 9;

  // reset values
  localparam logic [5:0] AST_CTRL_RESET = 6'h00;
  localparam logic [8:0] AST_HOLD_RESET = 9'h000;
  localparam logic AST_EMPTY_RESET = 1'b1;
  localparam logic AST_DONE_RESET = 1'b1;
  localparam logic [10:0] AST_SHIFT_RESET = 11'h7ff;

  // frame lengths in bit-times
  localparam logic [3:0] AST_FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] AST_FRAME_LEN_9 = 4'hb;

  // transmitter sequencer states
  typedef enum logic [2:0] {
    AST_ST_IDLE = 3'b000,
    AST_ST_MARK = 3'b001,
    AST_ST_DATA = 3'b010,
    AST_ST_PREAMBLE = 3'b011,
    AST_ST_BREAK = 3'b100,
    AST_ST_BRK_MARK = 3'b101
  } ast_tx_state_type;

endpackage : ast_pkg

// file: rtl/ast_reset_sync.sv
// reset release synchroniser for the serial transmitter
`timescale 1ns/1ps
`default_nettype none

module ast_reset_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n_sync
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } ast_sync_state_type;

  ast_sync_state_type s_q;
  ast_sync_state_type s_d;

  // shift a one in after release
  always_comb
  begin
    s_d = s_q;
    s_d.stage1 = 1'b1;
    s_d.stage2 = s_q.stage1;
  end

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rst_n_sync = s_q.stage2;

endmodule : ast_reset_sync

`default_nettype wire

// file: rtl/ast_transmitter.sv
// serial transmitter with shared data register and pin handover
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// Function
// R1: receive buffer read and holding write share one address, independent.
// R2: data bit 8 is the ninth bit only in nine-bit format.
// R3: data bits 7..0 are the first eight data bits.
// R4: every lower-byte data access triggers flag clearing and transmit start; here only a data write clears the armed flags.
// R5: shifter drives output pin while enabled or still finishing.
// R6: bit-time is one baud tick; frames are 10 or 11 bits.
// R7: enabling queues an all-ones preamble, after any word in progress.
// R8: after disable, finish shifter, preamble, break, then set done, release pin.
// R9: disable then enable mid-word sends preamble after word, then mark or data.
// R10: after preamble with no new data, output marks high.
// R11: holding write clears empty flag; write while clear overwrites pending.
// R12: at frame end a pending character moves to shifter, empty flag set.
// R13: frame is start bit, data, optional ninth bit, stop bit.
// R14: parity enable replaces last data bit with generated parity.
// R15: nothing queued at frame end sets done and keeps output high.
// R16: break finishes current character, then zero frames until break or enable clear.
// R17: a break is followed by at least one bit-time of mark.
// R18: open-drain select chooses drive style in serial and general use.
// R19: software waits for empty flag before clearing enable.
// R20: message gap: last byte, wait empty, toggle enable, write next byte.
// R21: reset sets empty; status read seeing flag then data write clears it.
// R22: parity sense odd or even comes from a control bit.
module ast_transmitter (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic baud_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [8:0] rx_char,
  output logic rx_char_read,
  input wire logic port_data_bit,
  input wire logic port_dir_bit,
  output logic txd_out,
  output logic txd_oe_n,
  output logic tx_active,
  output logic holding_empty_flag,
  output logic transmit_done
);

  typedef struct packed {
    logic [5:0] ctrl;
    logic [8:0] holding;
    logic empty;
    logic done;
    logic arm_empty;
    logic arm_done;
    logic [10:0] shifter;
    ast_pkg::ast_tx_state_type state;
    logic [3:0] bit_cnt;
    logic preamble_pend;
    logic [15:0] rdata;
    logic txd_out;
    logic txd_oe_n;
  } ast_tx_reg_type;

  ast_tx_reg_type s_q;
  ast_tx_reg_type s_d;
  logic rst_n;

  // build shifter image: start, data, ninth or parity, stop
  function automatic logic [10:0] build_frame(
    input logic [8:0] data,
    input logic ninth,
    input logic par_en,
    input logic par_odd
  );
    logic [8:0] d;
    d = data;
    if (!ninth)
    begin
      d[8] = 1'b1; // R13
    end
    if (par_en && ninth)
    begin
      d[8] = (^d[7:0]) ^ par_odd; // R14 R22
    end
    else if (par_en)
    begin
      d[7] = (^d[6:0]) ^ par_odd; // R14 R22
    end
    build_frame = {1'b1, d, 1'b0}; // R13
  endfunction : build_frame

  // frame length in bit-times for the current format
  function automatic logic [3:0] frame_len(input logic ninth);
    frame_len = ninth ? ast_pkg::AST_FRAME_LEN_9 : ast_pkg::AST_FRAME_LEN_8; // R6
  endfunction : frame_len

  ast_reset_sync u_reset_sync (
    .clk(clk),
    .arst_n(arst_n),
    .rst_n_sync(rst_n)
  );

  // control field views
  logic te;
  logic ninth;
  logic par_en;
  logic par_odd;
  logic brk;
  logic od;

  assign te = s_q.ctrl[ast_pkg::AST_CTRL_TE_BIT];
  assign ninth = s_q.ctrl[ast_pkg::AST_CTRL_NINTH_BIT];
  assign par_en = s_q.ctrl[ast_pkg::AST_CTRL_PE_BIT];
  assign par_odd = s_q.ctrl[ast_pkg::AST_CTRL_ODD_BIT];
  assign brk = s_q.ctrl[ast_pkg::AST_CTRL_BRK_BIT];
  assign od = s_q.ctrl[ast_pkg::AST_CTRL_OD_BIT];

  // register access decode
  logic wr_ctrl;
  logic wr_data;
  logic rd_ctrl;
  logic rd_status;
  logic rd_data;

  assign wr_ctrl = reg_wr && (reg_addr == ast_pkg::AST_ADDR_CTRL);
  assign wr_data = reg_wr && (reg_addr == ast_pkg::AST_ADDR_DATA); // R1 R4
  assign rd_ctrl = reg_rd && (reg_addr == ast_pkg::AST_ADDR_CTRL);
  assign rd_status = reg_rd && (reg_addr == ast_pkg::AST_ADDR_STATUS);
  assign rd_data = reg_rd && (reg_addr == ast_pkg::AST_ADDR_DATA); // R1 R4

  // sequencer timing views
  logic in_frame;
  logic frame_end;
  logic boundary;

  assign in_frame = (s_q.state == ast_pkg::AST_ST_DATA) ||
                    (s_q.state == ast_pkg::AST_ST_PREAMBLE) ||
                    (s_q.state == ast_pkg::AST_ST_BREAK);
  assign frame_end = baud_tick && in_frame &&
                     (s_q.bit_cnt == frame_len(ninth) - 4'h1); // R6
  assign boundary = frame_end ||
                    (baud_tick && (s_q.state == ast_pkg::AST_ST_IDLE)) ||
                    (baud_tick && (s_q.state == ast_pkg::AST_ST_MARK)) ||
                    (baud_tick && (s_q.state == ast_pkg::AST_ST_BRK_MARK)); // R17

  // pin ownership and level
  logic owns_pin;
  logic tx_bit;
  logic pin_val;
  logic pin_drive;

  assign owns_pin = te || (s_q.state != ast_pkg::AST_ST_IDLE); // R5 R8
  always_comb
  begin
    case (s_q.state)
      ast_pkg::AST_ST_DATA: tx_bit = s_q.shifter[0]; // R5
      ast_pkg::AST_ST_BREAK: tx_bit = 1'b0; // R16
      default: tx_bit = 1'b1; // R10 R15
    endcase
  end
  assign pin_val = owns_pin ? tx_bit : port_data_bit; // R8
  assign pin_drive = owns_pin || port_dir_bit;

  // next state of the whole block
  always_comb
  begin
    logic done_set;
    logic break_ok;
    done_set = 1'b0;
    break_ok = 1'b0;
    s_d = s_q;
    s_d.rdata = 16'h0000;

    // shift one bit per tick inside a frame
    if (baud_tick && in_frame && !frame_end)
    begin
      s_d.bit_cnt = s_q.bit_cnt + 4'h1; // R6
      s_d.shifter = {1'b1, s_q.shifter[10:1]}; // R6
    end

    // choose what follows at each bit boundary
    if (boundary)
    begin
      s_d.bit_cnt = 4'h0;
      break_ok = brk && (te || (s_q.state == ast_pkg::AST_ST_DATA)); // R8 R16
      if ((s_q.state == ast_pkg::AST_ST_BREAK) && !(brk && te))
      begin
        s_d.state = ast_pkg::AST_ST_BRK_MARK; // R17
      end
      else if (s_q.state == ast_pkg::AST_ST_BREAK)
      begin
        s_d.state = ast_pkg::AST_ST_BREAK; // R16
      end
      else if (s_q.preamble_pend)
      begin
        s_d.state = ast_pkg::AST_ST_PREAMBLE; // R7 R9
        s_d.preamble_pend = 1'b0;
      end
      else if (break_ok)
      begin
        s_d.state = ast_pkg::AST_ST_BREAK; // R16
      end
      else if (te && !s_q.empty)
      begin
        s_d.state = ast_pkg::AST_ST_DATA; // R12
        s_d.shifter = build_frame(s_q.holding, ninth, par_en, par_odd); // R12 R13
        s_d.empty = 1'b1; // R12
      end
      else if (te)
      begin
        s_d.state = ast_pkg::AST_ST_MARK; // R10 R15
        done_set = (s_q.state != ast_pkg::AST_ST_MARK); // R15
      end
      else
      begin
        s_d.state = ast_pkg::AST_ST_IDLE; // R8
        done_set = (s_q.state != ast_pkg::AST_ST_IDLE); // R8
      end
    end

    // control write; an enable rising edge queues a preamble
    if (wr_ctrl)
    begin
      s_d.ctrl = reg_wdata[ast_pkg::AST_CTRL_WIDTH-1:0];
      if (reg_wdata[ast_pkg::AST_CTRL_TE_BIT] && !te)
      begin
        s_d.preamble_pend = 1'b1; // R7 R9
      end
    end

    // holding write, armed flags clear
    if (wr_data)
    begin
      s_d.holding = reg_wdata[ast_pkg::AST_DATA_WIDTH-1:0]; // R1 R2 R3 R11
      if (s_q.arm_empty)
      begin
        s_d.empty = 1'b0; // R11 R21
        s_d.arm_empty = 1'b0;
      end
      if (s_q.arm_done)
      begin
        s_d.done = 1'b0; // R21
        s_d.arm_done = 1'b0;
      end
    end

    // status read arms the flags that are seen set
    if (rd_status)
    begin
      s_d.arm_empty = s_q.empty; // R21
      s_d.arm_done = s_q.done; // R21
    end

    // completion wins over a clear in the same cycle
    if (done_set)
    begin
      s_d.done = 1'b1;
    end

    // read data, valid the cycle after the strobe
    if (rd_ctrl)
    begin
      s_d.rdata = {10'h000, s_q.ctrl};
    end
    else if (rd_status)
    begin
      s_d.rdata = 16'h0000;
      s_d.rdata[ast_pkg::AST_STAT_EMPTY_BIT] = s_q.empty;
      s_d.rdata[ast_pkg::AST_STAT_DONE_BIT] = s_q.done;
    end
    else if (rd_data)
    begin
      s_d.rdata = {8'h00, rx_char[7:0]}; // R1 R3
      s_d.rdata[ast_pkg::AST_DATA_NINTH_BIT] = ninth & rx_char[8]; // R2
    end

    // pin drive: open-drain only pulls low
    s_d.txd_out = od ? 1'b0 : pin_val; // R18
    s_d.txd_oe_n = !(pin_drive && (!od || !pin_val)); // R18
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.ctrl <= ast_pkg::AST_CTRL_RESET;
      s_q.holding <= ast_pkg::AST_HOLD_RESET;
      s_q.empty <= ast_pkg::AST_EMPTY_RESET; // R21
      s_q.done <= ast_pkg::AST_DONE_RESET;
      s_q.arm_empty <= 1'b0;
      s_q.arm_done <= 1'b0;
      s_q.shifter <= ast_pkg::AST_SHIFT_RESET;
      s_q.state <= ast_pkg::AST_ST_IDLE;
      s_q.bit_cnt <= 4'h0;
      s_q.preamble_pend <= 1'b0;
      s_q.rdata <= 16'h0000;
      s_q.txd_out <= 1'b0;
      s_q.txd_oe_n <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata = s_q.rdata;
  assign rx_char_read = rd_data; // R4
  assign txd_out = s_q.txd_out;
  assign txd_oe_n = s_q.txd_oe_n;
  assign tx_active = s_q.state != ast_pkg::AST_ST_IDLE;
  assign holding_empty_flag = s_q.empty;
  assign transmit_done = s_q.done;

endmodule : ast_transmitter

`default_nettype wire

// file: testbench/ast_transmitter_chk.sv
// port checker for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic baud_tick,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [8:0] rx_char,
  input wire logic rx_char_read,
  input wire logic txd_out,
  input wire logic tx_active,
  input wire logic holding_empty_flag,
  input wire logic transmit_done
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // access decodes
  wire data_wr = reg_wr && (reg_addr == ast_pkg::AST_ADDR_DATA);
  wire data_rd = reg_rd && (reg_addr == ast_pkg::AST_ADDR_DATA);
  sequence stat_rd_s;
    reg_rd && (reg_addr == ast_pkg::AST_ADDR_STATUS);
  endsequence
  sequence quiet_s;
    !baud_tick && !reg_wr && tx_active;
  endsequence
  AST_RDATA_IDLE:
    assert property (!reg_rd |=> reg_rdata == 16'h0000) else $error("stray read data");
  AST_RX_READ:
    assert property (rx_char_read == data_rd) else $error("rx read pulse wrong");
  AST_DATA_READ:
    assert property (data_rd |=> reg_rdata[7:0] == $past(rx_char[7:0]))
    else $error("data read wrong");
  AST_STAT_READ:
    assert property (stat_rd_s |=> reg_rdata[8:7] == $past({holding_empty_flag, transmit_done}))
    else $error("status read wrong");
  AST_EMPTY_FALL:
    assert property ($fell(holding_empty_flag) |-> $past(data_wr)) else $error("empty fell");
  AST_DONE_FALL:
    assert property ($fell(transmit_done) |-> $past(data_wr)) else $error("done fell");
  AST_EMPTY_RISE:
    assert property ($rose(holding_empty_flag) |-> $past(baud_tick)) else $error("load off tick");
  AST_BIT_STEADY:
    assert property (quiet_s |-> ##2 $stable(txd_out)) else $error("bit changed mid bit");
endmodule : ast_transmitter_chk
bind ast_transmitter ast_transmitter_chk u_chk (.clk, .arst_n, .baud_tick, .reg_addr, .reg_wr,
  .reg_rd, .reg_rdata, .rx_char, .rx_char_read, .txd_out, .tx_active, .holding_empty_flag,
  .transmit_done);
`default_nettype wire

// file: testbench/ast_line_receiver.sv
// far-end serial receiver model on the transmit line
`timescale 1ns/1ps
`default_nettype none
module ast_line_receiver (
  input wire logic clk,
  input wire logic baud_tick,
  input wire logic line,
  input wire logic nine,
  output logic [9:0] rx_word,
  output var int rx_cnt
);
  int ph = 0;
  int left = 0;
  logic [9:0] w = 10'h000;
  initial rx_word = 10'h000;
  initial rx_cnt = 0;
  // mid-bit sampling: start, data lsb first, stop
  always @(posedge clk)
  begin
    ph <= baud_tick ? 0 : ph + 1;
    if (ph == 3 && left != 0)
    begin
      w[(nine ? 10 : 9) - left] = line;
      left <= left - 1;
      if (left == 1)
      begin
        rx_word <= w;
        rx_cnt <= rx_cnt + 1;
      end
    end
    else if (ph == 3 && line == 1'b0)
    begin
      w = 10'h000;
      left <= nine ? 10 : 9;
    end
  end
endmodule : ast_line_receiver
`default_nettype wire

// file: testbench/ast_transmitter_test.sv
// self-checking bench for the serial transmitter
`timescale 1ns/1ps
`default_nettype none
module ast_transmitter_test;
  localparam logic [3:0] A_CTRL = ast_pkg::AST_ADDR_CTRL;
  localparam logic [3:0] A_STAT = ast_pkg::AST_ADDR_STATUS;
  localparam logic [3:0] A_DATA = ast_pkg::AST_ADDR_DATA;
  typedef struct packed {logic [5:0] ctrl; logic [8:0] chr; logic [9:0] exp;} ast_row_type;
  ast_row_type rows [6] = '{'{6'h01, 9'h0a5, 10'h1a5}, '{6'h03, 9'h15a, 10'h35a},
    '{6'h05, 9'h0c1, 10'h141}, '{6'h0d, 9'h041, 10'h1c1}, '{6'h07, 9'h0ff, 10'h2ff},
    '{6'h0f, 9'h0ff, 10'h3ff}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic baud_tick = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [8:0] rx_char = 9'h000;
  logic port_data_bit = 1'b0;
  logic port_dir_bit = 1'b0;
  logic nine = 1'b0;
  wire logic [15:0] reg_rdata;
  wire logic rx_char_read, txd_out, txd_oe_n, tx_active, holding_empty_flag, transmit_done;
  wire logic [9:0] rx_word;
  wire logic line = (txd_oe_n === 1'b0) ? txd_out : 1'b1; // pull-up
  int rx_cnt;
  int miscompares = 0;
  int n_tests = 0;
  int cycles = 0;
  int n0;
  int t0;
  logic [15:0] d;
  ast_transmitter u_dut (.clk(clk), .arst_n(arst_n), .baud_tick(baud_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_char(rx_char), .rx_char_read(rx_char_read),
    .port_data_bit(port_data_bit), .port_dir_bit(port_dir_bit), .txd_out(txd_out),
    .txd_oe_n(txd_oe_n), .tx_active(tx_active), .holding_empty_flag(holding_empty_flag),
    .transmit_done(transmit_done));
  ast_line_receiver u_rx (.clk(clk), .baud_tick(baud_tick), .line(line), .nine(nine),
    .rx_word(rx_word), .rx_cnt(rx_cnt));
  initial forever #12.5 clk = ~clk;
  // bit-time tick every 8 cycles, and timeout
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    baud_tick <= (cycles % 8 == 7);
    if (cycles == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask : rd
  task automatic send(input logic [8:0] c);
    rd(A_STAT, d);
    wr(A_DATA, {7'h00, c});
    // let the write settle before flags are looked at
    @(negedge clk);
  endtask : send
  task automatic wait_rx(input int n);
    while (rx_cnt < n) @(posedge clk);
  endtask : wait_rx
  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    rx_char <= 9'h1b4;
    repeat (4) @(posedge clk);
    rd(A_STAT, d);
    check(d, 16'h0180);
    rd(4'hc, d);
    check(d, 16'h0000);
    wr(A_CTRL, 16'h0002);
    rd(A_CTRL, d);
    check(d, 16'h0002);
    rd(A_DATA, d);
    check(d, 16'h01b4);
    wr(A_CTRL, 16'h0000);
    rd(A_DATA, d);
    check(d, 16'h00b4);
    // frame formats, one row each
    foreach (rows[i])
    begin
      wr(A_CTRL, {10'h000, rows[i].ctrl});
      nine <= rows[i].ctrl[1];
      n0 = rx_cnt;
      send(rows[i].chr);
      check({15'h0000, holding_empty_flag}, 16'h0000);
      wait_rx(n0 + 1);
      check({6'h00, rx_word}, {6'h00, rows[i].exp});
      while (transmit_done !== 1'b1) @(posedge clk);
    end
    // overwrite of a pending character
    wr(A_CTRL, 16'h0001);
    nine <= 1'b0;
    n0 = rx_cnt;
    send(9'h011);
    while (holding_empty_flag !== 1'b1) @(posedge clk);
    send(9'h022);
    wr(A_DATA, 16'h0033);
    wait_rx(n0 + 2);
    check({6'h00, rx_word}, 16'h0133);
    // enable toggle mid-word queues a preamble
    while (transmit_done !== 1'b1) @(posedge clk);
    send(9'h044);
    while (holding_empty_flag !== 1'b1) @(posedge clk);
    wr(A_CTRL, 16'h0000);
    wr(A_CTRL, 16'h0001);
    send(9'h066);
    wait_rx(n0 + 3);
    t0 = cycles;
    wait_rx(n0 + 4);
    check({6'h00, rx_word}, 16'h0166);
    check({15'h0000, (cycles - t0) >= 150}, 16'h0001);
    // break then mark
    wr(A_CTRL, 16'h0011);
    repeat (200) @(posedge clk);
    check({15'h0000, line}, 16'h0000);
    wr(A_CTRL, 16'h0001);
    repeat (96) @(posedge clk);
    check({15'h0000, line}, 16'h0001);
    // disable hands the pin to the port bits
    port_dir_bit <= 1'b1;
    wr(A_CTRL, 16'h0000);
    while (tx_active === 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    check({14'h0000, txd_oe_n, txd_out}, 16'h0000);
    check({15'h0000, transmit_done}, 16'h0001);
    port_data_bit <= 1'b1;
    wr(A_CTRL, 16'h0020);
    repeat (2) @(posedge clk);
    check({14'h0000, txd_oe_n, txd_out}, 16'h0002);
    // open-drain low level is actively pulled down
    port_data_bit <= 1'b0;
    repeat (3) @(posedge clk);
    check({14'h0000, txd_oe_n, txd_out}, 16'h0000);
    tally_and_finish();
  end
endmodule : ast_transmitter_test
`default_nettype wire
